// ==== hdl/ufg_global_regs.sv ====
// global register slice of a full-speed usb core: queue status, config, id, periodic fifo size
// assumes a classic wishbone master on clk_i and core-side event strobes on the same clock
// Functional notes
// (R1) queue status is meaningful only in host mode; device mode reads are invalid
// (R2) bits 30:24 hold oldest queued request, 30:27 its channel number
// (R3) bits 26:25 give request type: token, zero-length out, channel halt
// (R4) bit 24 flags the last queued request of its channel
// (R5) bits 23:16 give free queue entries, 0 full up to 8
// (R6) bits 15:0 give free fifo words, never above configured depth
// (R7) config bit 21 ignores supply sense pin, supply treated as valid
// (R8) config bit 20 enables the start-of-frame pulse output
// (R9) config bits 19 and 18 enable b-side and a-side supply comparators
// (R10) config bit 16 powers the transceiver, reset value zero
// (R11) core identifier word is fully readable and writable
// (R12) software keeps periodic fifo depth between 1 and 1024 words
// (R13) bits 15:0 of periodic size register hold fifo base address in words
// (R14) software uses only full word accesses on periodic size register
// (R15) software keeps reserved config bits at reset value
// (R16) non-periodic fifo depth is programmed separately, 1 to 1024 words
// (R17) free space falls on pushes and rises on transmits and retires
`timescale 1ns/10ps
`include "ufg_params.svh"
module ufg_global_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic host_mode_i,
  input wire logic np_push_word_i,
  input wire logic np_pop_word_i,
  input wire logic np_req_push_i,
  input wire ufg_pkg::ufg_entry_s np_req_entry_i,
  input wire logic np_req_pop_i,
  input wire logic supply_pin_i,
  input wire logic frame_start_i,
  output logic supply_valid_o,
  output logic frame_pulse_o,
  output logic b_side_supply_cmp_en_o,
  output logic a_side_supply_cmp_en_o,
  output logic transceiver_power_o,
  output logic [15:0] periodic_fifo_depth_o,
  output logic [15:0] periodic_fifo_base_o
);
  ufg_pkg::ufg_wb_req_s req;
  ufg_pkg::ufg_entry_s np_queue_head_entry;
  logic [31:0] core_global_config;
  logic [31:0] core_identifier;
  logic [31:0] periodic_tx_fifo_size;
  logic [15:0] np_fifo_depth;
  logic [15:0] np_fifo_used;
  logic [7:0] np_queue_free_entries;
  logic [15:0] np_fifo_free_words;
  logic supply_meta;
  logic supply_sync;
  logic frame_meta;
  logic frame_sync;
  logic frame_prev;
  logic [31:0] next_dat;

  assign req.adr = adr_i;
  assign req.we = we_i;
  assign req.sel = sel_i;
  assign req.dat = dat_i;

  // single-cycle answer; ack drops after one cycle so back-to-back strobes re-arm
  wire access = cyc_i && stb_i && !ack_o && !err_o;
  wire hit_status = (req.adr == `UFG_OFF_NPQ_STATUS);
  wire hit_cfg = (req.adr == `UFG_OFF_GLOBAL_CFG);
  wire hit_id = (req.adr == `UFG_OFF_CORE_ID);
  wire hit_per = (req.adr == `UFG_OFF_PER_FIFO);
  wire hit_depth = (req.adr == `UFG_OFF_NP_FIFO_DEPTH);
  wire mapped = hit_status | hit_cfg | hit_id | hit_per | hit_depth;
  wire [31:0] byte_mask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
  wire wr = access && mapped && req.we;
  wire wr_cfg = wr && hit_cfg;
  wire wr_id = wr && hit_id;
  // partial writes here are software misuse; only a full word updates it
  wire wr_per = wr && hit_per && (req.sel == 4'hf); // R14
  wire wr_depth = wr && hit_depth && (req.sel[1:0] == 2'h3);
  // reserved config bits cannot be written, so they hold their reset value
  wire [31:0] cfg_wmask = byte_mask & `UFG_CFG_WMASK; // R15
  wire [31:0] next_cfg = (core_global_config & ~cfg_wmask) | (req.dat & cfg_wmask);
  wire [31:0] next_id = (core_identifier & ~byte_mask) | (req.dat & byte_mask); // R11

  // fifo occupancy tracking; word count saturates at the programmed depth
  wire np_push_ok = np_push_word_i && (np_fifo_used < np_fifo_depth);
  wire np_pop_ok = np_pop_word_i && (np_fifo_used != 16'h0);
  wire [15:0] next_np_used = np_fifo_used + {15'h0, np_push_ok} - {15'h0, np_pop_ok}; // R17
  assign np_fifo_free_words = (np_fifo_used >= np_fifo_depth) ? 16'h0 :
    np_fifo_depth - np_fifo_used; // R6

  ufg_req_queue u_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(np_req_push_i && host_mode_i),
    .push_entry_i(np_req_entry_i),
    .pop_i(np_req_pop_i && host_mode_i),
    .head_o(np_queue_head_entry),
    .free_o(np_queue_free_entries)
  );

  // status word: reserved bit 31 reads zero; in device mode the reset pattern is shown
  wire [31:0] status_word = host_mode_i ?
    {1'b0, np_queue_head_entry.channel, np_queue_head_entry.kind,
     np_queue_head_entry.terminate, np_queue_free_entries,
     np_fifo_free_words} : `UFG_RST_NPQ_STATUS; // R1 R2 R3 R4

  always_comb begin
    next_dat = 32'h0;
    if (hit_status) begin
      next_dat = status_word;
    end else if (hit_cfg) begin
      next_dat = core_global_config;
    end else if (hit_id) begin
      next_dat = core_identifier;
    end else if (hit_per) begin
      next_dat = periodic_tx_fifo_size;
    end else if (hit_depth) begin
      next_dat = {16'h0, np_fifo_depth};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= access && mapped;
      err_o <= access && !mapped;
      dat_o <= (access && mapped && !req.we) ? next_dat : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_global_config <= `UFG_RST_GLOBAL_CFG; // R10
    end else if (wr_cfg) begin
      core_global_config <= next_cfg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_identifier <= `UFG_RST_CORE_ID;
    end else if (wr_id) begin
      core_identifier <= next_id; // R11
    end
  end

  // depth limits are on software; the register stores what it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periodic_tx_fifo_size <= `UFG_RST_PER_FIFO;
    end else if (wr_per) begin
      periodic_tx_fifo_size <= req.dat; // R12 R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      np_fifo_depth <= `UFG_RST_NP_FIFO_DEPTH;
    end else if (wr_depth) begin
      np_fifo_depth <= req.dat[15:0]; // R16
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      np_fifo_used <= 16'h0;
    end else if (!host_mode_i) begin
      np_fifo_used <= 16'h0;
    end else begin
      np_fifo_used <= next_np_used;
    end
  end

  // pin inputs pass two flops before anything reads them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
      frame_meta <= 1'b0;
      frame_sync <= 1'b0;
      frame_prev <= 1'b0;
    end else begin
      supply_meta <= supply_pin_i;
      supply_sync <= supply_meta;
      frame_meta <= frame_start_i;
      frame_sync <= frame_meta;
      frame_prev <= frame_sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_valid_o <= 1'b0;
      frame_pulse_o <= 1'b0;
    end else begin
      supply_valid_o <= core_global_config[`UFG_BIT_SENSE_IGNORE] | supply_sync; // R7
      frame_pulse_o <= core_global_config[`UFG_BIT_FRAME_PULSE] &
        frame_sync & ~frame_prev; // R8
    end
  end

  assign b_side_supply_cmp_en_o = core_global_config[`UFG_BIT_B_CMP]; // R9
  assign a_side_supply_cmp_en_o = core_global_config[`UFG_BIT_A_CMP]; // R9
  assign transceiver_power_o = core_global_config[`UFG_BIT_XCVR_POWER]; // R10
  assign periodic_fifo_depth_o = periodic_tx_fifo_size[31:16];
  assign periodic_fifo_base_o = periodic_tx_fifo_size[15:0]; // R13
endmodule // ufg_global_regs

// ==== hdl/ufg_params.svh ====
// constants for the full-speed core global register slice
// assumes a 32-bit classic wishbone slave with word addressing by byte offset
`ifndef UFG_PARAMS_SVH
`define UFG_PARAMS_SVH
`define UFG_OFF_NPQ_STATUS 12'h02c
`define UFG_OFF_GLOBAL_CFG 12'h038
`define UFG_OFF_CORE_ID 12'h03c
`define UFG_OFF_PER_FIFO 12'h100
`define UFG_OFF_NP_FIFO_DEPTH 12'h028
`define UFG_RST_NPQ_STATUS 32'h00080200
`define UFG_RST_GLOBAL_CFG 32'h00000000
// identifier reset value is arbitrary; software overwrites it with its own id
`define UFG_RST_CORE_ID 32'h5a5a0001
`define UFG_RST_PER_FIFO 32'h02000600
`define UFG_RST_NP_FIFO_DEPTH 16'h0200
`define UFG_QUEUE_ENTRIES 8'h08
`define UFG_QUEUE_DEPTH 8
`define UFG_BIT_SENSE_IGNORE 21
`define UFG_BIT_FRAME_PULSE 20
`define UFG_BIT_B_CMP 19
`define UFG_BIT_A_CMP 18
`define UFG_BIT_XCVR_POWER 16
`define UFG_CFG_WMASK 32'h003d0000
`endif

// ==== hdl/ufg_pkg.sv ====
// types for the full-speed core global register slice
// assumes nothing beyond the params header
package ufg_pkg;
  typedef enum logic [1:0] {
    ufg_req_token = 2'h0,
    ufg_req_zlp = 2'h1,
    ufg_req_halt = 2'h3
  } ufg_req_e;
  typedef struct packed {
    logic [3:0] channel;
    ufg_req_e kind;
    logic terminate;
  } ufg_entry_s;
  typedef struct packed {
    logic [11:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } ufg_wb_req_s;
endpackage

// ==== hdl/ufg_req_queue.sv ====
// request queue of the non-periodic transmit path, eight entries in flip-flops
// assumes push and pop come from logic on the same clock
`timescale 1ns/10ps
`include "ufg_params.svh"
module ufg_req_queue (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire ufg_pkg::ufg_entry_s push_entry_i,
  input wire logic pop_i,
  output ufg_pkg::ufg_entry_s head_o,
  output logic [7:0] free_o
);
  ufg_pkg::ufg_entry_s mem [`UFG_QUEUE_DEPTH];
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  logic [3:0] count;
  wire full = (count == 4'(`UFG_QUEUE_DEPTH));
  wire empty = (count == 4'h0);
  wire do_push = push_i && !full;
  wire do_pop = pop_i && !empty;
  // free space never exceeds the queue depth
  assign free_o = `UFG_QUEUE_ENTRIES - {4'h0, count}; // R5
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count <= 4'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      count <= count + {3'h0, do_push} - {3'h0, do_pop}; // R17
    end
  end
  genvar g;
  generate
    for (g = 0; g < `UFG_QUEUE_DEPTH; g = g + 1) begin : g_entry
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mem[g] <= '0;
        end else if (do_push && wr_ptr == 3'(g)) begin
          mem[g] <= push_entry_i;
        end
      end
    end
  endgenerate
  // empty queue shows an all-zero head entry
  assign head_o = empty ? '0 : mem[rd_ptr];
endmodule // ufg_req_queue

// ==== verification/ufg_global_regs_chk.sv ====
// port-level assertions for the global register slice
// assumes a bind onto ufg_global_regs, one clock domain
`timescale 1ns/10ps
module ufg_global_regs_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic host_mode_i,
  input wire logic supply_valid_o,
  input wire logic frame_pulse_o,
  input wire logic b_side_supply_cmp_en_o,
  input wire logic a_side_supply_cmp_en_o,
  input wire logic transceiver_power_o,
  input wire logic [15:0] periodic_fifo_base_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic cw;
  logic st;
  logic sof;
  assign cw = cyc_i && stb_i && we_i && ack_o && adr_i == 12'h038 && sel_i[2];
  assign st = cyc_i && stb_i && !we_i && ack_o && adr_i == 12'h02c;
  // shadow of the frame enable; lags the design, so only the off state is judged
  always_ff @(posedge clk_i) begin
    if (rst_i) sof <= 1'b0;
    else if (cw) sof <= dat_i[20];
  end
  chk_status_device: assert property (st && !host_mode_i |-> dat_o == 32'h00080200)
    else $error("status not at reset value in device mode");
  chk_queue_fields: assert property (st |-> !dat_o[31] && dat_o[26:25] != 2'b10
    && dat_o[23:16] <= 8'h08) else $error("queue status field out of range");
  chk_words_bound: assert property (st |-> dat_o[15:0] <= 16'h0400)
    else $error("free words above depth");
  chk_ignore_supply: assert property (cw && dat_i[21] |-> ##[1:3] supply_valid_o)
    else $error("supply not valid with ignore set");
  chk_frame_gated: assert property (!sof && !$past(sof) && !$past(sof, 2)
    |-> !frame_pulse_o) else $error("frame pulse while disabled");
  chk_cfg_outputs: assert property (cw |=> {b_side_supply_cmp_en_o, a_side_supply_cmp_en_o,
    transceiver_power_o} == {$past(dat_i[19:18]), $past(dat_i[16])})
    else $error("config outputs differ from written bits");
  chk_power_reset: assert property ($fell(rst_i) |-> !transceiver_power_o)
    else $error("transceiver powered after reset");
  chk_base_write: assert property (cyc_i && stb_i && we_i && ack_o && adr_i == 12'h100
    |=> periodic_fifo_base_o == ($past(sel_i) == 4'hf ? $past(dat_i[15:0])
    : $past(periodic_fifo_base_o))) else $error("base field write wrong");
endmodule // ufg_global_regs_chk

bind ufg_global_regs ufg_global_regs_chk u_ufg_global_regs_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .host_mode_i(host_mode_i), .supply_valid_o(supply_valid_o),
  .frame_pulse_o(frame_pulse_o), .b_side_supply_cmp_en_o(b_side_supply_cmp_en_o),
  .a_side_supply_cmp_en_o(a_side_supply_cmp_en_o),
  .transceiver_power_o(transceiver_power_o), .periodic_fifo_base_o(periodic_fifo_base_o));

// ==== verification/ufg_usb_side.sv ====
// far-side stand-in: bus supply sense and frame starts
// assumes run_i comes from the bench on the same clock
`timescale 1ns/10ps
module ufg_usb_side (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic supply_i,
  output logic supply_pin_o,
  output logic frame_start_o
);
  logic [3:0] cnt = 4'h0;
  // supply follows the bench so sense monitoring can be seen with ignore clear
  assign supply_pin_o = supply_i;
  assign frame_start_o = run_i && cnt[3];
  always_ff @(posedge clk_i) begin
    cnt <= cnt + 4'h1;
  end
endmodule // ufg_usb_side

// ==== verification/ufg_global_regs_tb.sv ====
// self-checking bench for the global register slice
// assumes the design, its bound checker and the far-side model
`timescale 1ns/10ps
module ufg_global_regs_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs = 1'b0, hm = 1'b1, run = 1'b0, pw = 1'b0, pp = 1'b0, rq = 1'b0, rp = 1'b0;
  ufg_pkg::ufg_wb_req_s r = '0;
  ufg_pkg::ufg_entry_s ent = '0;
  ufg_pkg::ufg_entry_s e [9];
  logic [31:0] dat_o, d;
  logic ack_o, err_o, sv, fp, bc, ac, pwr, sp, fs;
  logic [15:0] dep, base;
  logic [33:0] q [$];
  logic [33:0] n;
  logic [7:0] pulses = 8'h0;
  logic spl = 1'b0;
  int seed = 32'h0d30;
  int b [4] = '{16, 18, 19, 21};
  int mismatches = 0, n_compared = 0;
  ufg_global_regs u_ufg_global_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cs), .stb_i(cs),
    .we_i(r.we), .adr_i(r.adr), .sel_i(r.sel), .dat_i(r.dat), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .host_mode_i(hm), .np_push_word_i(pw), .np_pop_word_i(pp),
    .np_req_push_i(rq), .np_req_entry_i(ent), .np_req_pop_i(rp), .supply_pin_i(sp),
    .frame_start_i(fs), .supply_valid_o(sv), .frame_pulse_o(fp), .b_side_supply_cmp_en_o(bc),
    .a_side_supply_cmp_en_o(ac), .transceiver_power_o(pwr), .periodic_fifo_depth_o(dep),
    .periodic_fifo_base_o(base));
  ufg_usb_side u_ufg_usb_side (.clk_i(clk_i), .run_i(run), .supply_i(spl), .supply_pin_o(sp),
    .frame_start_o(fs));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // note the expectation first; the monitor judges it when the answer comes
  task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s,
      input logic [31:0] v, input logic x);
    q.push_back({!w, x, v});
    cs <= 1'b1;
    r <= '{a, w, s, v};
    do @(posedge clk_i); while (!(ack_o | err_o));
    cs <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (fp) pulses <= pulses + 8'h1;
    if (ack_o | err_o) begin
      n = q.pop_front();
      chk({31'h0, err_o}, {31'h0, n[32]});
      if (n[33]) chk(dat_o, n[31:0]);
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, pwr}, 32'h0);
    wb(1'b0, 12'h02c, 4'hf, 32'h00080200, 1'b0);
    wb(1'b0, 12'h100, 4'hf, 32'h02000600, 1'b0);
    wb(1'b0, 12'h004, 4'hf, 32'h0, 1'b1);
    $display("reset test done");
    wb(1'b1, 12'h038, 4'hf, 32'hffffffff, 1'b0);
    wb(1'b0, 12'h038, 4'hf, 32'h003d0000, 1'b0);
    run <= 1'b1;
    d[7:0] = pulses;
    repeat (64) @(posedge clk_i);
    chk({31'h0, pulses - d[7:0] > 8'h2}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 12'h038, 4'h4, 32'h1 << b[i], 1'b0);
      @(posedge clk_i);
      chk({28'h0, sv, bc, ac, pwr}, 32'h1 << i);
    end
    d[7:0] = pulses;
    repeat (64) @(posedge clk_i);
    chk({24'h0, pulses - d[7:0]}, 32'h0);
    wb(1'b1, 12'h038, 4'h4, 32'h0, 1'b0);
    spl <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({31'h0, sv}, 32'h1);
    spl <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({31'h0, sv}, 32'h0);
    $display("config test done");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wb(1'b1, 12'h03c, 4'hf, d, 1'b0);
      wb(1'b0, 12'h03c, 4'hf, d, 1'b0);
    end
    wb(1'b1, 12'h03c, 4'h2, 32'h0000a500, 1'b0);
    wb(1'b0, 12'h03c, 4'hf, {d[31:16], 8'ha5, d[7:0]}, 1'b0);
    d = $random(seed);
    d[31:16] = 16'h0001 + {6'h0, d[25:16]};
    wb(1'b1, 12'h100, 4'hf, d, 1'b0);
    wb(1'b1, 12'h100, 4'h3, 32'h0, 1'b0);
    wb(1'b0, 12'h100, 4'hf, d, 1'b0);
    chk({dep, base}, d);
    $display("id and periodic test done");
    wb(1'b1, 12'h028, 4'hf, 32'h00000004, 1'b0);
    for (int i = 0; i < 9; i++) begin
      e[i] = {4'($random(seed)), i % 3 == 1 ? 2'h1 : (i % 3 == 2 ? 2'h3 : 2'h0), 1'(i)};
      ent <= e[i];
      rq <= 1'b1;
      pw <= 1'b1;
      @(posedge clk_i);
    end
    rq <= 1'b0;
    pw <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      wb(1'b0, 12'h02c, 4'hf, {1'b0, e[j], 8'(j), 16'(j)}, 1'b0);
      rp <= 1'b1;
      pp <= 1'b1;
      @(posedge clk_i);
      rp <= 1'b0;
      pp <= 1'b0;
    end
    hm <= 1'b0;
    wb(1'b0, 12'h02c, 4'hf, 32'h00080200, 1'b0);
    chk(q.size(), 32'h0);
    $display("queue test done");
    results();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    results();
  end
endmodule // ufg_global_regs_tb
